// ### hdl/bus_ready_waitstate_control.sv
// Purpose: External bus cycle sequencer with memory, READY and post-cycle waitstates
// Assumes: Requests are always synchronous; READY pin level is synchronous unless async mode is set
// Notes: ready_b is active low; low at the sampling point ends the cycle
`timescale 1ns/1ps
`default_nettype none
`include "bus_cfg.svh"

module bus_ready_waitstate_control (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [`REG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic cycle_req,
   input wire logic cycle_is_write,
   output logic cycle_accept,
   output logic cycle_done,
   input wire logic ready_b,
   output logic read_strobe_b,
   output logic write_strobe_b,
   output logic system_clock_output
);
   logic [`CFG_W-1:0] config_reg;
   bus_pkg::bus_state_type state_reg;
   bus_pkg::bus_state_type state_next;
   logic [`CFG_WS_W-1:0] ws_count_reg;
   logic [`READY_WS_W-1:0] ready_ws_reg;
   logic is_write_reg;
   logic cycle_done_reg;
   logic read_strobe_b_reg;
   logic write_strobe_b_reg;
   logic [31:0] reg_rdata_reg;
   logic [`CFG_WS_W-1:0] mem_ws;
   logic rw_delay_en;
   logic mux_mode;
   logic tristate_en;
   logic ready_ctrl_en;
   logic not_ready;
   logic sample_point;
   logic end_now;
   logic strobe_next;

   ready_sync_if rdy_if ();

   ready_sync sync_inst (
      .clock (clock),
      .rst_b (rst_b),
      .rdy (rdy_if.sync)
   );

   assign rdy_if.ready_b_pin = ready_b;
   assign rdy_if.async_mode = config_reg[`CFG_ASYNC_BIT];
   assign mem_ws = config_reg[`CFG_WS_LSB +: `CFG_WS_W];
   assign rw_delay_en = config_reg[`CFG_RW_DELAY_BIT];
   assign mux_mode = config_reg[`CFG_MUX_BIT];
   assign tristate_en = config_reg[`CFG_TRISTATE_BIT];
   assign ready_ctrl_en = config_reg[`CFG_READY_EN_BIT];
   // A responder that releases READY on the trailing strobe edge is seen as not ready
   assign not_ready = rdy_if.ready_b_used;

   // READY is looked at once the programmed waitstates are used up
   assign sample_point = (state_reg == bus_pkg::COMMAND && ws_count_reg == '0)
      || state_reg == bus_pkg::READY_WAIT;
   assign end_now = sample_point && !(ready_ctrl_en && not_ready);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bus_pkg::IDLE: begin
            if (cycle_req) begin
               state_next = rw_delay_en ? bus_pkg::RW_DELAY : bus_pkg::COMMAND;
            end
         end
         bus_pkg::RW_DELAY: begin
            state_next = bus_pkg::COMMAND;
         end
         bus_pkg::COMMAND, bus_pkg::READY_WAIT: begin
            if (end_now) begin
               if (mux_mode) begin
                  state_next = bus_pkg::MUX_WAIT;
               end else if (tristate_en) begin
                  state_next = bus_pkg::TRI_WAIT;
               end else begin
                  state_next = bus_pkg::IDLE;
               end
            end else if (sample_point) begin
               state_next = bus_pkg::READY_WAIT;
            end
         end
         bus_pkg::MUX_WAIT: begin
            state_next = tristate_en ? bus_pkg::TRI_WAIT : bus_pkg::IDLE;
         end
         bus_pkg::TRI_WAIT: begin
            state_next = bus_pkg::IDLE;
         end
         default: begin
            state_next = bus_pkg::IDLE;
         end
      endcase
   end

   assign strobe_next = state_next == bus_pkg::COMMAND || state_next == bus_pkg::READY_WAIT;
   assign cycle_accept = state_reg == bus_pkg::IDLE && cycle_req;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_reg <= bus_pkg::IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Memory waitstate countdown, loaded on entry to the command phase
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ws_count_reg <= '0;
      end else if (state_next == bus_pkg::COMMAND && state_reg != bus_pkg::COMMAND) begin
         ws_count_reg <= mem_ws;
      end else if (state_reg == bus_pkg::COMMAND && ws_count_reg != '0) begin
         ws_count_reg <= ws_count_reg - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         is_write_reg <= 1'b0;
      end else if (cycle_accept) begin
         is_write_reg <= cycle_is_write;
      end
   end

   // Strobes driven from flops so the pins carry no decode glitches
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         read_strobe_b_reg <= 1'b1;
         write_strobe_b_reg <= 1'b1;
      end else begin
         read_strobe_b_reg <= !(strobe_next && !(cycle_accept ? cycle_is_write : is_write_reg));
         write_strobe_b_reg <= !(strobe_next && (cycle_accept ? cycle_is_write : is_write_reg));
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cycle_done_reg <= 1'b0;
      end else begin
         cycle_done_reg <= (state_reg == bus_pkg::COMMAND || state_reg == bus_pkg::READY_WAIT)
            && end_now;
      end
   end

   // READY waitstates of the current or last cycle, saturating
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ready_ws_reg <= '0;
      end else if (cycle_accept) begin
         ready_ws_reg <= '0;
      end else if (state_next == bus_pkg::READY_WAIT && ready_ws_reg != '1) begin
         ready_ws_reg <= ready_ws_reg + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         config_reg <= `CFG_RESET;
      end else if (reg_write && reg_addr == `REG_CONFIG) begin
         config_reg <= reg_wdata[`CFG_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         reg_rdata_reg <= 32'h00000000;
      end else if (reg_read && reg_addr == `REG_CONFIG) begin
         reg_rdata_reg <= {{(32-`CFG_W){1'b0}}, config_reg};
      end else if (reg_read && reg_addr == `REG_STATUS) begin
         reg_rdata_reg <= {16'h0000, ready_ws_reg, 1'b0, state_reg, 3'h0,
            state_reg != bus_pkg::IDLE};
      end else begin
         reg_rdata_reg <= 32'h00000000;
      end
   end

   assign reg_rdata = reg_rdata_reg;
   assign cycle_done = cycle_done_reg;
   assign read_strobe_b = read_strobe_b_reg;
   assign write_strobe_b = write_strobe_b_reg;
   // CPU clock forwarded; the responder times READY against it
   assign system_clock_output = clock;

   // Helper: cycles spent in the command phase of the current cycle
   logic [`CFG_WS_W:0] cmd_len_reg;
   always_ff @(posedge clock) begin
      if (!rst_b || state_reg != bus_pkg::COMMAND) begin
         cmd_len_reg <= '0;
      end else begin
         cmd_len_reg <= cmd_len_reg + 1'b1;
      end
   end

   sequence post_two;
      ##1 state_reg == bus_pkg::MUX_WAIT ##1 state_reg == bus_pkg::TRI_WAIT
         ##1 state_reg == bus_pkg::IDLE;
   endsequence

   sequence strobe_delayed;
      ##1 (read_strobe_b && write_strobe_b) ##1 !(read_strobe_b && write_strobe_b);
   endsequence

   AST_READY_HIGH_WAITS: assert property (@(posedge clock) disable iff (!rst_b)
      sample_point && ready_ctrl_en && not_ready
      |=> state_reg == bus_pkg::READY_WAIT && !(read_strobe_b && write_strobe_b))
      else $error("READY high did not add a waitstate");
   AST_READY_LOW_ENDS: assert property (@(posedge clock) disable iff (!rst_b)
      sample_point && !not_ready |=> cycle_done && read_strobe_b && write_strobe_b)
      else $error("READY low did not end the cycle");
   AST_MEM_WAITSTATES: assert property (@(posedge clock) disable iff (!rst_b)
      state_reg == bus_pkg::COMMAND && state_next != bus_pkg::COMMAND
      |-> cmd_len_reg == {1'b0, mem_ws})
      else $error("command phase length differs from memory waitstates");
   AST_RW_DELAY_ON: assert property (@(posedge clock) disable iff (!rst_b)
      cycle_accept && rw_delay_en |-> strobe_delayed)
      else $error("strobe not delayed by one cycle");
   AST_RW_DELAY_OFF: assert property (@(posedge clock) disable iff (!rst_b)
      cycle_accept && !rw_delay_en |=> !(read_strobe_b && write_strobe_b))
      else $error("strobe not asserted at once");
   AST_MUX_WAIT: assert property (@(posedge clock) disable iff (!rst_b)
      cycle_done && mux_mode |-> state_reg == bus_pkg::MUX_WAIT)
      else $error("multiplex waitstate missing");
   AST_POST_TWO: assert property (@(posedge clock) disable iff (!rst_b)
      end_now && mux_mode && tristate_en && !reg_write |-> post_two)
      else $error("muxed tristate post delay is not two clocks");
   AST_POST_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
      end_now && !mux_mode && !tristate_en |=> state_reg == bus_pkg::IDLE)
      else $error("demuxed post delay not zero");
   AST_NO_EARLY_START: assert property (@(posedge clock) disable iff (!rst_b)
      state_reg == bus_pkg::MUX_WAIT || state_reg == bus_pkg::TRI_WAIT
      |-> !cycle_accept ##1 (read_strobe_b && write_strobe_b))
      else $error("next cycle started inside post delay");
endmodule
`default_nettype wire

// ### hdl/bus_cfg.svh
// Purpose: Constants for the READY-driven external bus cycle controller
// Assumes: 10 MHz CPU clock, byte-addressed register port with 8-bit address
// Notes: Register offsets are word aligned
`ifndef BUS_CFG_SVH
`define BUS_CFG_SVH

`define REG_ADDR_W 8
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04

// Configuration register fields
`define CFG_WS_LSB 0
`define CFG_WS_W 4
`define CFG_RW_DELAY_BIT 4
`define CFG_MUX_BIT 5
`define CFG_TRISTATE_BIT 6
`define CFG_READY_EN_BIT 7
`define CFG_ASYNC_BIT 8
`define CFG_W 9
`define CFG_RESET 9'h000

// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_STATE_LSB 4
`define STAT_READY_WS_LSB 8
`define READY_WS_W 8

`endif

// ### hdl/bus_pkg.sv
// Purpose: Types shared by the bus cycle controller files
// Assumes: Nothing beyond the constants header
// Notes: State order is visible in the status register
package bus_pkg;
   typedef enum logic [2:0] {
      IDLE,
      RW_DELAY,
      COMMAND,
      READY_WAIT,
      MUX_WAIT,
      TRI_WAIT
   } bus_state_type;
endpackage

// ### hdl/ready_sync_if.sv
// Purpose: Carries the READY pin, its mode and the qualified level
// Assumes: One clock domain
// Notes: Used between the controller and the READY synchroniser
`timescale 1ns/1ps
`default_nettype none
interface ready_sync_if;
   logic ready_b_pin;
   logic async_mode;
   logic ready_b_used;
   modport controller (output ready_b_pin, output async_mode, input ready_b_used);
   modport sync (input ready_b_pin, input async_mode, output ready_b_used);
endinterface
`default_nettype wire

// ### hdl/ready_sync.sv
// Purpose: Two-stage synchroniser for an asynchronous READY input
// Assumes: Synchronous READY meets setup and hold to the clock
// Notes: Async mode adds two cycles of latency to READY recognition
`timescale 1ns/1ps
`default_nettype none
module ready_sync (
   input wire logic clock,
   input wire logic rst_b,
   ready_sync_if.sync rdy
);
   logic meta_reg;
   logic stable_reg;

   // Reset to not-ready so a stale level cannot end a cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         meta_reg <= 1'b1;
         stable_reg <= 1'b1;
      end else begin
         meta_reg <= rdy.ready_b_pin;
         stable_reg <= meta_reg;
      end
   end

   assign rdy.ready_b_used = rdy.async_mode ? stable_reg : rdy.ready_b_pin;

   AST_SYNC_TWO_STAGE: assert property (@(posedge clock) disable iff (!rst_b)
      rdy.async_mode && $past(rst_b, 2) |-> rdy.ready_b_used == $past(rdy.ready_b_pin, 2))
      else $error("async READY not delayed by two stages");
endmodule
`default_nettype wire

// ### bench/ready_responder.sv
// Purpose: External responder driving the active-low READY pin
// Assumes: ready_at is at least 2 strobe-low cycles
// Notes: READY is released one edge after the strobe rises
`timescale 1ns/1ps
`default_nettype none
module ready_responder (
   input wire logic clock,
   input wire logic read_strobe_b,
   input wire logic write_strobe_b,
   input wire logic [7:0] ready_at,
   output var logic ready_b
);
   logic [7:0] low_cnt_reg;
   initial begin
      low_cnt_reg = 8'h00;
      ready_b = 1'b1;
   end
   always @(posedge clock) begin
      if (read_strobe_b && write_strobe_b) begin
         low_cnt_reg <= 8'h00;
         ready_b <= 1'b1;
      end else begin
         low_cnt_reg <= low_cnt_reg + 8'h01;
         // Held low for whole cycles, far beyond the asynchronous minimum
         ready_b <= !(low_cnt_reg + 8'h01 >= ready_at - 8'h01);
      end
   end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench for the READY waitstate controller
// Assumes: Config is changed only while the controller is idle
// Notes: Outputs are judged at the falling edge, where they have settled; the forwarded clock also 10 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "bus_cfg.svh"
module tb;
   logic clock, rst_b, reg_write, reg_read, cycle_req, cycle_is_write;
   logic [7:0] reg_addr, ready_at;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic cycle_accept, cycle_done, ready_b, read_strobe_b, write_strobe_b;
   logic system_clock_output;
   int failures = 0;
   int num_checks = 0;
   bus_ready_waitstate_control u_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .cycle_req(cycle_req), .cycle_is_write(cycle_is_write),
      .cycle_accept(cycle_accept), .cycle_done(cycle_done), .ready_b(ready_b),
      .read_strobe_b(read_strobe_b), .write_strobe_b(write_strobe_b),
      .system_clock_output(system_clock_output));
   ready_responder u_resp (.clock(clock), .read_strobe_b(read_strobe_b),
      .write_strobe_b(write_strobe_b), .ready_at(ready_at), .ready_b(ready_b));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
      @(posedge clock);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
      @(posedge clock);
      reg_addr <= addr;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      data = reg_rdata;
   endtask
   // Two back-to-back cycles; request stays up so the post-cycle gap is measured
   task automatic pair(input logic wr, input logic [8:0] cfg, input logic [7:0] k,
         input int expd, input int expl, input int expg);
      int d, l, g;
      reg_wr(`REG_CONFIG, {23'h0, cfg});
      ready_at <= k;
      @(posedge clock);
      cycle_req <= 1'b1;
      cycle_is_write <= wr;
      g = 0;
      do begin
         @(negedge clock);
         g++;
      end while (cycle_accept !== 1'b1 && g < 20);
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         if (i == 1) cycle_req <= 1'b0;
         d = 0;
         l = 0;
         do begin
            @(negedge clock);
            d++;
         end while ((wr ? write_strobe_b : read_strobe_b) !== 1'b0 && d < 20);
         check("strobe delay", d, expd);
         check("other strobe idle", wr ? read_strobe_b : write_strobe_b, 1'b1);
         while ((wr ? write_strobe_b : read_strobe_b) === 1'b0 && l < 40) begin
            l++;
            @(negedge clock);
         end
         check("strobe low cycles", l, expl);
         check("cycle done", cycle_done, 1'b1);
         if (i == 0) begin
            g = 0;
            while (cycle_accept !== 1'b1 && g < 20) begin
               @(negedge clock);
               g++;
            end
            check("post cycle gap", g, expg);
         end
      end
      repeat (3) @(posedge clock);
   endtask
   // Reset values, read-only status, unmapped reads and the forwarded clock
   task automatic reg_checks();
      reg_rd(`REG_CONFIG, v);
      check("config reset", v, 32'h0);
      reg_wr(`REG_STATUS, 32'hFFFF_FFFF);
      reg_rd(`REG_STATUS, v);
      check("status read only", v, 32'h0);
      reg_rd(8'h08, v);
      check("unmapped read", v, 32'h0);
      check("clock output", system_clock_output, 1'b0);
      @(posedge clock);
      #10;
      check("clock output high", system_clock_output, 1'b1);
   endtask
   // A long READY-held cycle read mid-way must show busy, state and the count so far
   task automatic busy_status();
      int g;
      reg_wr(`REG_CONFIG, 32'h0000_0080);
      ready_at <= 8'h10;
      @(posedge clock);
      cycle_req <= 1'b1;
      cycle_is_write <= 1'b0;
      @(posedge clock);
      cycle_req <= 1'b0;
      reg_rd(`REG_STATUS, v);
      check("status mid cycle", v, 32'h0000_0131);
      check("read strobe held", read_strobe_b, 1'b0);
      check("write strobe idle", write_strobe_b, 1'b1);
      g = 0;
      while (cycle_done !== 1'b1 && g < 40) begin
         @(negedge clock);
         g++;
      end
      check("long cycle ends", cycle_done, 1'b1);
      reg_rd(`REG_STATUS, v);
      check("ready waitstates long", v, 32'h0000_0F00);
   endtask
   initial begin
      rst_b = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      cycle_req = 1'b0;
      cycle_is_write = 1'b0;
      ready_at = 8'h02;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      reg_checks();
      pair(1'b0, 9'h000, 8'h02, 1, 1, 0);
      pair(1'b1, 9'h013, 8'h02, 2, 4, 0);
      pair(1'b0, 9'h0A1, 8'h04, 1, 4, 1);
      reg_rd(`REG_STATUS, v);
      check("ready waitstates", v, 32'h0000_0200);
      busy_status();
      pair(1'b1, 9'h0E0, 8'h02, 1, 2, 2);
      pair(1'b0, 9'h042, 8'h02, 1, 3, 1);
      pair(1'b1, 9'h1E2, 8'h03, 1, 5, 2);
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge clock);
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire
